// ---- hdl/drc_top.sv ----
/*
 * Line-interface controller register bank with the control-one functions:
 * self-clearing soft reset, call-progress output mode and enable, and the
 * digital loopback across the isolation barrier.
 * Assumes one AHB-Lite master, word transfers only, and line-side samples
 * that arrive on hclk with a one-cycle sample strobe from this block.
 */
// Register access over AHB-Lite was decided locally.

//
// Contract
// - soft reset restores all registers, then self-clears
// - mode field picks waveform; code three reserved
// - mode zero: density stream at modulator rate
// - mode one: pulse centred on sample period
// - mode two: low at boundary, rises by amplitude
// - pin driven only while enable bit set
// - loopback returns transmit data through both filters
// - loopback works without a valid line
module drc_top
    import drc_pkg::*;
#(
    // identity values below are arbitrary
    parameter logic [DATA_W-1:0] SYS_REVISION  = 8'h01,
    parameter logic [DATA_W-1:0] LINE_REVISION = 8'h02,
    parameter logic [DATA_W-1:0] LINE_IDENTITY = 8'h03
)
(
    // clock and reset
    input  wire logic                         hclk,
    input  wire logic                         hresetn,
    // ahb-lite slave
    input  wire logic                         hsel,
    input  wire logic [31:0]                  haddr,
    input  wire logic [1:0]                   htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic [31:0]                  hwdata,
    input  wire logic                         hready,
    output logic                              hreadyout,
    output logic                              hresp,
    output logic [31:0]                       hrdata,
    // line-side status
    input  wire logic [drc_pkg::DATA_W-1:0]   line_status,
    input  wire logic [drc_pkg::DATA_W-1:0]   dropout_status,
    input  wire logic [drc_pkg::DATA_W-1:0]   line_voltage,
    // sample paths
    input  wire logic [drc_pkg::SAMPLE_W-1:0] tx_from_host,
    input  wire logic [drc_pkg::SAMPLE_W-1:0] rx_from_line,
    output logic [drc_pkg::SAMPLE_W-1:0]      tx_to_line,
    output logic [drc_pkg::SAMPLE_W-1:0]      rx_to_host,
    output logic                              sample_strobe,
    // call-progress pin
    output logic                              call_progress_out_pin,
    output logic                              call_progress_out_oe
);
    import drc_pkg::*;

    drc_wave_if wv ();

    logic [DATA_W-1:0]   bank_r [NREG];
    logic                soft_rst_r;
    logic                wr_pend_r;
    logic                rd_wait_r;
    logic                hit_r;
    logic [IDX_W-1:0]    idx_r;
    logic                hreadyout_r;
    logic [31:0]         hrdata_r;
    logic [SAMPLE_W-1:0] tx_stage_r;
    logic [SAMPLE_W-1:0] rx_stage_r;
    logic                strobe_r;
    logic                pin_r;
    logic                oe_r;

    // address phase decode
    wire                 addr_go  = hsel && hready && htrans[1];
    wire                 addr_hit = (haddr[31:IDX_W+2] == '0) && (haddr[1:0] == 2'b00);
    wire  [IDX_W-1:0]    addr_idx = haddr[IDX_W+1:2];
    wire                 wr_go    = wr_pend_r && hreadyout_r && hit_r;
    wire  [DATA_W-1:0]   wr_byte  = hwdata[DATA_W-1:0];
    wire                 sr_go    = wr_go && (idx_r == IDX_CONTROL_ONE)
                                    && wr_byte[SOFT_RST_BIT];

    // control-one fields
    wire  [DATA_W-1:0]   ctrl1      = bank_r[IDX_CONTROL_ONE];
    wire  [1:0]          mode_bits  = ctrl1[MODE_MSB:MODE_LSB];
    wire                 out_enable = ctrl1[ENABLE_BIT];
    wire                 loop_en    = ctrl1[LOOP_BIT];

    // read selection
    wire  [DATA_W-1:0]   rd_ctrl1 = {soft_rst_r, ctrl1[SOFT_RST_BIT-1:0]};
    wire  [DATA_W-1:0]   rd_byte  =
        !hit_r                          ? RST_ZERO      :
        (idx_r == IDX_CONTROL_ONE)      ? rd_ctrl1      :
        (idx_r == IDX_SYS_REVISION)     ? SYS_REVISION  :
        (idx_r == IDX_LINE_STATUS)      ? line_status   :
        (idx_r == IDX_LINE_REVISION)    ? LINE_REVISION :
        (idx_r == IDX_DROPOUT_DETECT)   ? dropout_status :
        (idx_r == IDX_LINE_VOLTAGE)     ? line_voltage  :
        (idx_r == IDX_LINE_IDENTITY)    ? LINE_IDENTITY :
                                          bank_r[idx_r];

    // level for the waveform: transmit plus receive, offset binary
    wire  [SAMPLE_W:0]   mix_sum  = {tx_stage_r[SAMPLE_W-1], tx_stage_r}
                                    + {rx_stage_r[SAMPLE_W-1], rx_stage_r};
    wire  [CNT_W-1:0]    mix_lvl  = {~mix_sum[SAMPLE_W], mix_sum[SAMPLE_W-1 -: CNT_W-1]};

    assign wv.level  = mix_lvl;
    assign wv.mode   = drc_mode_t'(mode_bits);
    assign wv.enable = out_enable;

    drc_wave_gen u_wave (
        .hclk    (hclk),
        .hresetn (hresetn),
        .wv      (wv)
    );

    // ahb data-phase tracking; reads take one wait state
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_r <= 1'b0;
            rd_wait_r <= 1'b0;
            hit_r     <= 1'b0;
            idx_r     <= '0;
        end
        else if (addr_go)
        begin
            wr_pend_r <= hwrite;
            rd_wait_r <= !hwrite;
            hit_r     <= addr_hit;
            idx_r     <= addr_idx;
        end
        else
        begin
            if (hreadyout_r)
                wr_pend_r <= 1'b0;
            rd_wait_r <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hreadyout_r <= 1'b1;
        else
            hreadyout_r <= !(addr_go && !hwrite);
    end

    // read data is taken in the wait state so a preceding write has landed
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_r <= '0;
        else if (rd_wait_r)
            hrdata_r <= {24'h000000, rd_byte};
    end

    // soft reset stands for one cycle and clears itself
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            soft_rst_r <= 1'b0;
        else
            soft_rst_r <= sr_go;
    end

    // one storage entry per index; unwritable bits never hold a one
    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++)
        begin : g_bank
            localparam logic [IDX_W-1:0] GIDX = IDX_W'(gi);
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    bank_r[gi] <= drc_rst_val(GIDX);
                else if (soft_rst_r)
                    bank_r[gi] <= drc_rst_val(GIDX);
                else if (wr_go && idx_r == GIDX)
                    bank_r[gi] <= wr_byte & drc_wr_mask(GIDX);
            end
        end
    endgenerate

    // filter stages; loopback takes the transmit stage back into receive,
    // independent of any line-side status
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tx_stage_r <= '0;
            rx_stage_r <= '0;
        end
        else if (wv.smp_en)
        begin
            tx_stage_r <= tx_from_host;
            rx_stage_r <= loop_en ? tx_stage_r : rx_from_line;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            strobe_r <= 1'b0;
            pin_r    <= 1'b0;
            oe_r     <= 1'b0;
        end
        else
        begin
            strobe_r <= wv.smp_en;
            pin_r    <= wv.wave;
            oe_r     <= out_enable;
        end
    end

    assign hreadyout             = hreadyout_r;
    assign hresp                 = 1'b0;
    assign hrdata                = hrdata_r;
    assign tx_to_line            = tx_stage_r;
    assign rx_to_host            = rx_stage_r;
    assign sample_strobe         = strobe_r;
    assign call_progress_out_pin = pin_r;
    assign call_progress_out_oe  = oe_r;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_sr_self_clear: assert property (sr_go |=> soft_rst_r ##1 !soft_rst_r)
        else $error("soft reset bit did not clear itself");
    a_sr_restores: assert property (soft_rst_r |=> (ctrl1 == RST_ZERO)
                                    && (bank_r[IDX_CONTROL_TWO] == RST_CONTROL_TWO))
        else $error("soft reset did not restore register values");
    a_reserved_quiet: assert property ((mode_bits == MODE_RESERVED) |=> !call_progress_out_pin)
        else $error("pin active in reserved mode");
    a_disabled_pin: assert property (!out_enable |=> !call_progress_out_pin
                                     && !call_progress_out_oe)
        else $error("pin driven while disabled");
    a_loop_path: assert property ((wv.smp_en && loop_en) |=> rx_to_host == $past(tx_to_line))
        else $error("loopback did not return transmit data");
    a_reserved_bits: assert property ((ctrl1 & ~CTRL1_STORE_MASK) == RST_ZERO)
        else $error("reserved control bits hold a one");
    a_read_wait: assert property ((addr_go && !hwrite) |=> !hreadyout ##1 hreadyout)
        else $error("read wait state not exactly one cycle");
    a_read_value: assert property ((rd_wait_r && hit_r && idx_r == IDX_CONTROL_ONE)
                                   |=> hrdata[2] == 1'b0 && hrdata[0] == 1'b0)
        else $error("reserved control bits read non-zero");

    c_loopback: cover property (loop_en && wv.smp_en);
    c_centred:  cover property (mode_bits == MODE_CENTRED && call_progress_out_pin);
    c_trailing: cover property (mode_bits == MODE_TRAILING && call_progress_out_pin);
    c_soft_rst: cover property (sr_go);

endmodule // drc_top

// ---- hdl/drc_pkg.sv ----
/*
 * Shared constants of the line-interface register bank: register indices,
 * control-one field layout, reset values, waveform modes and clock rates.
 * Assumes a single 50 MHz system clock; all slower rates are enables.
 */
package drc_pkg;

    // register word and index widths
    localparam int DATA_W    = 8;
    localparam int IDX_W     = 6;
    localparam int NREG      = 64;
    localparam int SAMPLE_W  = 16;
    localparam int CNT_W     = 9;

    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CONTROL_ONE      = 6'h01;
    localparam logic [IDX_W-1:0] IDX_CONTROL_TWO      = 6'h02;
    localparam logic [IDX_W-1:0] IDX_INTERRUPT_MASK   = 6'h03;
    localparam logic [IDX_W-1:0] IDX_INTERRUPT_STATUS = 6'h04;
    localparam logic [IDX_W-1:0] IDX_LINE_CONTROL_ONE = 6'h05;
    localparam logic [IDX_W-1:0] IDX_LINE_CONTROL_TWO = 6'h06;
    localparam logic [IDX_W-1:0] IDX_SAMPLE_RATE_CTRL = 6'h07;
    localparam logic [IDX_W-1:0] IDX_LINE_CONTROL_THR = 6'h0A;
    localparam logic [IDX_W-1:0] IDX_SYS_REVISION     = 6'h0B;
    localparam logic [IDX_W-1:0] IDX_LINE_STATUS      = 6'h0C;
    localparam logic [IDX_W-1:0] IDX_LINE_REVISION    = 6'h0D;
    localparam logic [IDX_W-1:0] IDX_GAIN_CONTROL     = 6'h0F;
    localparam logic [IDX_W-1:0] IDX_CALIBRATION      = 6'h11;
    localparam logic [IDX_W-1:0] IDX_INTL_CONTROL_THR = 6'h12;
    localparam logic [IDX_W-1:0] IDX_DROPOUT_DETECT   = 6'h13;
    localparam logic [IDX_W-1:0] IDX_PROGRESS_RX_ATT  = 6'h14;
    localparam logic [IDX_W-1:0] IDX_PROGRESS_TX_ATT  = 6'h15;
    localparam logic [IDX_W-1:0] IDX_RING_VALID_ONE   = 6'h16;
    localparam logic [IDX_W-1:0] IDX_RING_VALID_TWO   = 6'h17;
    localparam logic [IDX_W-1:0] IDX_RING_VALID_THR   = 6'h18;
    localparam logic [IDX_W-1:0] IDX_LINE_VOLTAGE     = 6'h1D;
    localparam logic [IDX_W-1:0] IDX_LINE_IDENTITY    = 6'h3C;

    // control-one field layout
    localparam int SOFT_RST_BIT   = 7;
    localparam int MODE_LSB       = 4;
    localparam int MODE_MSB       = 5;
    localparam int ENABLE_BIT     = 3;
    localparam int LOOP_BIT       = 1;
    localparam logic [DATA_W-1:0] CTRL1_STORE_MASK = 8'h3A;

    // reset values and the full write mask
    localparam logic [DATA_W-1:0] RST_ZERO        = 8'h00;
    localparam logic [DATA_W-1:0] RST_CONTROL_TWO = 8'h03;
    localparam logic [DATA_W-1:0] MASK_ALL        = 8'hFF;

    // waveform selection on the call-progress pin
    typedef enum logic [1:0] {
        MODE_DENSITY  = 2'b00,
        MODE_CENTRED  = 2'b01,
        MODE_TRAILING = 2'b10,
        MODE_RESERVED = 2'b11
    } drc_mode_t;

    // rates in kHz; the modulator enable comes from a phase accumulator
    localparam logic [16:0] CLK_KHZ  = 17'd50000;
    localparam logic [16:0] MOD_KHZ  = 17'd16384;
    localparam logic [16:0] SMP_KHZ  = 17'd32;
    localparam int          SMP_TICKS = int'(MOD_KHZ / SMP_KHZ);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SMP_TICKS - 1);
    localparam logic [CNT_W-1:0] CNT_MID  = CNT_W'(SMP_TICKS / 2);

    // bits that software may store in each register
    function automatic logic [DATA_W-1:0] drc_wr_mask(input logic [IDX_W-1:0] idx);
        case (idx)
            IDX_CONTROL_ONE:                            drc_wr_mask = CTRL1_STORE_MASK;
            IDX_CONTROL_TWO, IDX_INTERRUPT_MASK,
            IDX_INTERRUPT_STATUS, IDX_LINE_CONTROL_ONE,
            IDX_LINE_CONTROL_TWO, IDX_SAMPLE_RATE_CTRL,
            IDX_LINE_CONTROL_THR, IDX_GAIN_CONTROL,
            IDX_CALIBRATION, IDX_INTL_CONTROL_THR,
            IDX_PROGRESS_RX_ATT, IDX_PROGRESS_TX_ATT,
            IDX_RING_VALID_ONE, IDX_RING_VALID_TWO,
            IDX_RING_VALID_THR:                         drc_wr_mask = MASK_ALL;
            default:                                    drc_wr_mask = RST_ZERO;
        endcase
    endfunction

    function automatic logic [DATA_W-1:0] drc_rst_val(input logic [IDX_W-1:0] idx);
        drc_rst_val = (idx == IDX_CONTROL_TWO) ? RST_CONTROL_TWO : RST_ZERO;
    endfunction

endpackage

// ---- hdl/drc_wave_if.sv ----
/*
 * Carrier between the register bank and the call-progress waveform
 * generator. Assumes both ends run on the same clock.
 */
interface drc_wave_if;
    import drc_pkg::*;

    logic                 mod_en;
    logic                 smp_en;
    logic [CNT_W-1:0]     level;
    drc_mode_t            mode;
    logic                 enable;
    logic                 wave;

    modport bank (input mod_en, input smp_en, output level, output mode,
                  output enable, input wave);
    modport gen  (output mod_en, output smp_en, input level, input mode,
                  input enable, output wave);
endinterface

// ---- hdl/drc_wave_gen.sv ----
/*
 * Call-progress waveform generator: modulator and sample-clock enables
 * from the system clock, and the three pulse shapes.
 * Assumes hclk at 50 MHz and an offset-binary level from the bank.
 */
module drc_wave_gen
    import drc_pkg::*;
(
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // bank side
    drc_wave_if.gen   wv
);

    logic [16:0]      ph_r;
    logic             mod_en_r;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] level_r;
    logic [CNT_W-1:0] sd_acc_r;
    logic             sd_bit_r;

    // fractional divider: 16.384 MHz does not divide 50 MHz evenly
    wire  [16:0]      ph_sum   = ph_r + MOD_KHZ;
    wire              ph_wrap  = ph_sum >= CLK_KHZ;
    wire  [16:0]      ph_nxt   = ph_wrap ? ph_sum - CLK_KHZ : ph_sum;
    wire              smp_en   = mod_en_r && (cnt_r == CNT_LAST);
    wire  [CNT_W:0]   sd_sum   = {1'b0, sd_acc_r} + {1'b0, level_r};
    wire  [CNT_W-1:0] half     = {1'b0, level_r[CNT_W-1:1]};
    wire  [CNT_W-1:0] ctr_lo   = CNT_MID - half;
    wire  [CNT_W:0]   ctr_hi   = {1'b0, CNT_MID} + {1'b0, half};
    wire              w_ctr    = (cnt_r >= ctr_lo) && ({1'b0, cnt_r} < ctr_hi);
    wire              w_trail  = cnt_r > level_r;
    wire              w_sel    = (wv.mode == MODE_DENSITY)  ? sd_bit_r :
                                 (wv.mode == MODE_CENTRED)  ? w_ctr    :
                                 (wv.mode == MODE_TRAILING) ? w_trail  : 1'b0;

    assign wv.mod_en = mod_en_r;
    assign wv.smp_en = smp_en;
    assign wv.wave   = wv.enable && w_sel;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ph_r     <= '0;
            mod_en_r <= 1'b0;
        end
        else
        begin
            ph_r     <= ph_nxt;
            mod_en_r <= ph_wrap;
        end
    end

    // period counter of the 32 kHz sample clock
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cnt_r <= '0;
        else if (mod_en_r)
            cnt_r <= cnt_r + 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            level_r <= '0;
        else if (smp_en)
            level_r <= wv.level;
    end

    // first-order density modulator, one decision per modulator tick
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sd_acc_r <= '0;
            sd_bit_r <= 1'b0;
        end
        else if (mod_en_r)
        begin
            sd_acc_r <= sd_sum[CNT_W-1:0];
            sd_bit_r <= sd_sum[CNT_W];
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_density_tick: assert property (!mod_en_r |=> $stable(sd_bit_r))
        else $error("density bit changed off a modulator tick");
    a_centred_edges: assert property ((wv.mode == MODE_CENTRED && cnt_r == '0) |-> !wv.wave)
        else $error("centred pulse high at period boundary");
    a_centred_mid: assert property ((wv.mode == MODE_CENTRED && wv.enable && level_r > 9'h001
                                     && cnt_r == CNT_MID) |-> wv.wave)
        else $error("centred pulse low at period centre");
    a_trailing_boundary: assert property ((wv.mode == MODE_TRAILING && cnt_r == '0) |-> !wv.wave)
        else $error("trailing pulse not low at period start");
    a_mod_spacing: assert property (mod_en_r |=> !mod_en_r)
        else $error("modulator enable back to back");

endmodule // drc_wave_gen

// ---- sim/drc_tb.sv ----
/*
 * Self-checking bench for the line-interface register bank: bus access,
 * soft reset, call-progress waveforms and barrier loopback.
 * Assumes the design carries its own assertions and hready = hreadyout.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import drc_pkg::*;

    logic                hclk = 1'b0;
    logic                hresetn, hsel, hwrite, noise;
    logic [1:0]          htrans;
    logic [2:0]          hsize;
    logic [31:0]         haddr, hwdata, hrdata;
    logic                hreadyout, hresp, sample_strobe, pin, oe;
    logic [DATA_W-1:0]   st_line, st_drop, st_volt;
    logic [SAMPLE_W-1:0] tx_in, rx_in, tx_out, rx_out;
    logic [31:0]         exp_q[$];
    logic                rd_pend;
    int                  n_fail, total_checks, cycles;

    localparam logic [IDX_W-1:0] RW_IDX [16] = '{IDX_CONTROL_ONE, IDX_CONTROL_TWO,
        IDX_INTERRUPT_MASK, IDX_INTERRUPT_STATUS, IDX_LINE_CONTROL_ONE, IDX_LINE_CONTROL_TWO,
        IDX_SAMPLE_RATE_CTRL, IDX_LINE_CONTROL_THR, IDX_GAIN_CONTROL, IDX_CALIBRATION,
        IDX_INTL_CONTROL_THR, IDX_PROGRESS_RX_ATT, IDX_PROGRESS_TX_ATT, IDX_RING_VALID_ONE,
        IDX_RING_VALID_TWO, IDX_RING_VALID_THR};

    drc_top dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .line_status(st_line),
        .dropout_status(st_drop), .line_voltage(st_volt), .tx_from_host(tx_in),
        .rx_from_line(rx_in), .tx_to_line(tx_out), .rx_to_host(rx_out),
        .sample_strobe(sample_strobe), .call_progress_out_pin(pin),
        .call_progress_out_oe(oe)
    );

    always #10 hclk = ~hclk;

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // master keeps each phase until hready is sampled high
    task automatic bus(input logic [IDX_W-1:0] idx, input logic wr, input logic [7:0] d);
        @(posedge hclk);
        htrans <= 2'b10;
        haddr  <= {24'h000000, idx, 2'b00};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {24'h000000, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask

    task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
        bus(idx, 1'b1, d);
    endtask

    task automatic rd(input logic [IDX_W-1:0] idx, input logic [7:0] e);
        exp_q.push_back({24'h000000, e});
        bus(idx, 1'b0, 8'h00);
    endtask

    function automatic logic [7:0] rst_of(input logic [IDX_W-1:0] idx);
        return (idx == IDX_CONTROL_TWO) ? 8'h03 : 8'h00;
    endfunction

    task automatic wait_strobe();
        do @(posedge hclk); while (sample_strobe !== 1'b1);
    endtask

    // edges of the pin over one full sample period, and low seen near its start
    task automatic cnt(output int n, output logic lo);
        logic p;
        int   k;
        n = 0;
        k = 0;
        lo = 1'b0;
        wait_strobe();
        p = pin;
        do
        begin
            @(posedge hclk);
            k++;
            if (pin !== p)
                n++;
            if (k < 5 && pin === 1'b0)
                lo = 1'b1;
            p = pin;
        end
        while (sample_strobe !== 1'b1);
    endtask

    // read results are compared where the bus returns them
    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 80000)
        begin
            n_fail++;
            final_report();
        end
        else if (!hresetn)
            rd_pend = 1'b0;
        else if (hreadyout === 1'b1)
        begin
            if (rd_pend)
            begin
                check(hresp, 32'h0);
                if (exp_q.size() == 0)
                    check(hrdata, 32'hFFFFFFFF);
                else
                    check(hrdata, exp_q.pop_front());
            end
            rd_pend = hsel && htrans[1] && !hwrite;
        end
    end

    // a missing line is modelled as data that changes every cycle
    always @(posedge hclk)
        if (!hresetn)
            rx_in <= '0;
        else if (noise)
            rx_in <= SAMPLE_W'($urandom);

    initial
    begin
        logic [7:0] sh [16];
        logic [7:0] d;
        int         n;
        logic       lo;
        void'($urandom(48));
        hresetn <= 1'b0;
        hsel    <= 1'b1;
        hsize   <= 3'b010;
        htrans  <= 2'b00;
        hwrite  <= 1'b0;
        haddr   <= 32'h00000000;
        hwdata  <= 32'h00000000;
        noise   <= 1'b0;
        st_line <= DATA_W'($urandom);
        st_drop <= DATA_W'($urandom);
        st_volt <= DATA_W'($urandom);
        tx_in   <= 16'h1000;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (RW_IDX[i]) rd(RW_IDX[i], rst_of(RW_IDX[i]));
        rd(IDX_SYS_REVISION, 8'h01);
        rd(IDX_LINE_REVISION, 8'h02);
        rd(IDX_LINE_IDENTITY, 8'h03);
        rd(IDX_LINE_STATUS, st_line);
        rd(IDX_DROPOUT_DETECT, st_drop);
        rd(IDX_LINE_VOLTAGE, st_volt);
        wr(IDX_SYS_REVISION, 8'hFF);
        rd(IDX_SYS_REVISION, 8'h01);
        wr(6'h08, 8'hFF);
        rd(6'h08, 8'h00);
        foreach (RW_IDX[i])
        begin
            d = 8'($urandom) | 8'h05;
            // bit seven would reset the bank; loopback is kept off here and tested on its own below
            if (RW_IDX[i] == IDX_CONTROL_ONE)
                d = d & 8'h3D;
            sh[i] = (RW_IDX[i] == IDX_CONTROL_ONE) ? (d & 8'h3A) : d;
            wr(RW_IDX[i], d);
            rd(RW_IDX[i], sh[i]);
        end
        wr(IDX_CONTROL_ONE, 8'h80);
        foreach (RW_IDX[i]) rd(RW_IDX[i], rst_of(RW_IDX[i]));
        repeat (2) @(posedge hclk);
        check(oe, 32'h0);
        cnt(n, lo);
        check(n, 32'h0);
        check(pin, 32'h0);
        for (int m = 0; m < 4; m++)
        begin
            wr(IDX_CONTROL_ONE, {2'b00, 2'(m), 4'b1000});
            cnt(n, lo);
            check(oe, 32'h1);
            cnt(n, lo);
            case (m)
                0: check(n > 2, 32'h1);
                1: check(n, 32'h2);
                2: check({n[30:0], lo}, {31'h2, 1'b1});
                default: check(n, 32'h0);
            endcase
        end
        wr(IDX_LINE_CONTROL_TWO, 8'h00);
        wr(IDX_LINE_CONTROL_ONE, 8'h01);
        wr(IDX_CONTROL_ONE, 8'h02);
        rd(IDX_CONTROL_ONE, 8'h02);
        tx_in <= SAMPLE_W'($urandom);
        noise <= 1'b1;
        repeat (3) wait_strobe();
        check(rx_out, tx_in);
        check(tx_out, tx_in);
        wr(IDX_CONTROL_ONE, 8'h00);
        noise <= 1'b0;
        repeat (3) wait_strobe();
        check(rx_out, rx_in);
        repeat (4) @(posedge hclk);
        check(exp_q.size(), 32'h0);
        final_report();
    end
endmodule // tb
